/* File: dasmc_params.svh */
/*
 Offsets, field positions, reset values and mode codes of the converter
 mode and status registers.
 Assumes an 8-bit special function register bus with 8-bit addresses.
*/
`ifndef DASMC_PARAMS_SVH
`define DASMC_PARAMS_SVH

// ========
// Register offsets
`define DASMC_MODE_ADDR      8'hd1
`define DASMC_STAT_ADDR      8'hd8

// ========
// Reset values
`define DASMC_MODE_RESET     8'h00
`define DASMC_STAT_RESET     8'h00

// ========
// Mode register fields
`define DASMC_MODE_PEN_BIT   5
`define DASMC_MODE_AEN_BIT   4
`define DASMC_MODE_FLD_HI    2
`define DASMC_MODE_FLD_LO    0

// ========
// Status register fields
`define DASMC_STAT_PRDY_BIT  7
`define DASMC_STAT_ARDY_BIT  6
`define DASMC_STAT_CAL_BIT   5
`define DASMC_STAT_NREF_BIT  4
`define DASMC_STAT_PERR_BIT  3
`define DASMC_STAT_AERR_BIT  2

// ========
// Operating mode codes
`define DASMC_MD_PDOWN       3'h0
`define DASMC_MD_IDLE        3'h1
`define DASMC_MD_SINGLE      3'h2
`define DASMC_MD_CONT        3'h3

`endif

/* File: dasmc_pkg.sv */
/*
 Types shared by the converter mode and status logic.
 Assumes the constants of dasmc_params.svh.
*/
package dasmc_pkg;

   // ==================================================================
   // Per-converter run state, Gray coded along off, run, stop
   typedef enum logic [1:0] {
      CS_OFF  = 2'b00,
      CS_RUN  = 2'b01,
      CS_STOP = 2'b11,
      CS_HOLD = 2'b10
   } dasmc_conv_state_t;

   typedef logic [2:0] dasmc_mode_t;

endpackage : dasmc_pkg

/* File: dasmc_conv_seq.sv */
/*
 Run-state sequencer for one converter: power, filter reset, modulator
 clock, and the acceptance of finished conversions and calibrations.
 Assumes a one-cycle done pulse from the filter and a mode register
 write strobe from the register logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dasmc_params.svh"

module dasmc_conv_seq (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   // Mode
   input  wire logic                  convEnable,
   input  wire dasmc_pkg::dasmc_mode_t modeField,
   input  wire logic                  modeWrite,
   // Filter side
   input  wire logic                  convDone,
   input  wire logic                  clampIn,
   input  wire logic                  calFaultIn,
   input  wire logic                  calInhibit,
   input  wire logic                  readyHeld,
   // State
   output logic                       powerOn,
   output logic                       filterRst,
   output logic                       modClkEn,
   // Events
   output logic                       resultLoad,
   output logic                       coefLoad,
   output logic                       readySet,
   output logic                       errSet,
   output logic                       calSet,
   output logic                       cycleEnd
);

   dasmc_pkg::dasmc_conv_state_t stateReg;
   dasmc_pkg::dasmc_conv_state_t stateNext;
   logic                         resetPulse_reg;
   logic                         active;
   logic                         calMode;
   logic                         oneShot;
   logic                         accept;

   // ==================================================================
   // Mode decode
   assign active  = convEnable && (modeField != `DASMC_MD_PDOWN);      // R12 R13 R14
   assign calMode = modeField[2];
   assign oneShot = calMode || (modeField == `DASMC_MD_SINGLE);

   // ==================================================================
   // Converter reset on any mode write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         resetPulse_reg <= 1'b0;
      end else begin
         resetPulse_reg <= modeWrite;                                     // R19
      end
   end

   // ==================================================================
   // Run state
   always_comb begin
      stateNext = stateReg;
      if (resetPulse_reg || !active) begin
         if (!active) begin
            stateNext = dasmc_pkg::CS_OFF;
         end else if (modeField == `DASMC_MD_IDLE) begin
            stateNext = dasmc_pkg::CS_HOLD;                               // R15
         end else begin
            stateNext = dasmc_pkg::CS_RUN;
         end
      end else if (accept && oneShot) begin
         stateNext = dasmc_pkg::CS_STOP;                                  // R16
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stateReg <= dasmc_pkg::CS_OFF;
      end else begin
         stateReg <= stateNext;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         powerOn   <= 1'b0;
         filterRst <= 1'b1;
         modClkEn  <= 1'b0;
      end else begin
         case (stateNext)
            dasmc_pkg::CS_RUN: begin
               powerOn   <= 1'b1;
               filterRst <= modeWrite;                                    // R19
               modClkEn  <= 1'b1;
            end
            dasmc_pkg::CS_HOLD: begin
               powerOn   <= 1'b1;
               filterRst <= 1'b1;                                         // R15
               modClkEn  <= 1'b1;                                         // R15
            end
            default: begin
               powerOn   <= 1'b0;
               filterRst <= 1'b1;
               modClkEn  <= 1'b0;
            end
         endcase
      end
   end

   // ==================================================================
   // Completion events
   assign accept     = (stateReg == dasmc_pkg::CS_RUN) && !resetPulse_reg && !modeWrite
                       && convDone && !readyHeld;                         // R3
   assign resultLoad = accept && !calMode;                                // R18
   assign coefLoad   = accept && calMode && !calInhibit && !calFaultIn;   // R9 R21
   assign readySet   = accept;                                            // R1
   assign errSet     = accept && (calMode ? (calInhibit || calFaultIn) : clampIn); // R8 R9
   assign calSet     = accept && calMode;                                 // R5
   assign cycleEnd   = accept && oneShot;                                 // R17

endmodule : dasmc_conv_seq
`default_nettype wire

/* File: dasmc_top.sv */
/*
 Mode and status registers for a primary and an auxiliary sigma-delta
 converter, with the sequencing that ties them to the converters.
 Assumes a synchronous byte-wide register bus from the core and filter
 logic that pulses a done line at the end of each cycle.
*/
// What this block does
// R1: Primary ready, status bit 7, set when a primary conversion or calibration ends.
// R2: Primary ready clears on software zero write or a launching mode write.
// R3: While ready is set, the converter writes no new result or coefficients.
// R4: Status bit 6 is auxiliary ready, behaving like the primary ready.
// R5: Status bit 5 set on calibration end, cleared only by a launching mode write.
// R6: Missing-reference bit 4 follows the detector only while a converter is active.
// R7: Missing reference with external reference in use forces results to all ones.
// R8: Status bit 3 set when the primary result was clamped to a limit.
// R9: After calibration the error bit flags a fault blocking coefficient update.
// R10: Primary error clears when a mode write starts conversion or calibration.
// R11: Status bit 2 is the auxiliary error bit, like the primary one.
// R12: Mode bit 5 enables the primary converter; cleared keeps it powered down.
// R13: Mode bit 4 enables the auxiliary converter; cleared keeps it powered down.
// R14: Mode field 000 is power-down and the reset value.
// R15: Idle holds filter and modulator in reset with modulator clocks running.
// R16: Single mode performs exactly one conversion per enabled converter, then stops.
// R17: Single conversion end updates results, flags, and writes mode field to 000.
// R18: Continuous mode keeps refreshing results without returning to power-down.
// R19: Any mode register write resets both converters, even with equal value.
// R20: Calibration write clears both ready flags; completion sets mode field 000.
// R21: Auxiliary calibration with temperature input sets ready and error, no coefficients.
`timescale 1ns/1ps
`default_nettype none
`include "dasmc_params.svh"

module dasmc_top (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Register bus
   input  wire logic [7:0]  sfrAddr,
   input  wire logic        sfrWrEn,
   input  wire logic        sfrRdEn,
   input  wire logic [7:0]  sfrWrData,
   output logic      [7:0]  sfrRdData,
   // Filter and analog side
   input  wire logic [1:0]  convDone,
   input  wire logic [1:0]  clampIn,
   input  wire logic [1:0]  calFaultIn,
   input  wire logic [1:0]  extRefSel,
   input  wire logic        refMissingIn,
   input  wire logic        auxTempSelected,
   input  wire logic [23:0] primaryRaw,
   input  wire logic [15:0] auxiliaryRaw,
   // Converter control
   output logic      [1:0]  convPowerOn,
   output logic      [1:0]  convFilterRst,
   output logic      [1:0]  convModClkEn,
   output logic      [2:0]  opModeOut,
   // Results and coefficients
   output logic      [23:0] primaryResult,
   output logic      [15:0] auxiliaryResult,
   output logic      [1:0]  resultStrobe,
   output logic      [1:0]  coefStrobe
);

   // ==================================================================
   // Decode helpers
   function automatic logic launches(input logic [2:0] md);
      launches = (md == `DASMC_MD_SINGLE) || (md == `DASMC_MD_CONT) || md[2];
   endfunction : launches

   function automatic logic isOneShot(input logic [2:0] md);
      isOneShot = (md == `DASMC_MD_SINGLE) || md[2];
   endfunction : isOneShot

   // ==================================================================
   // Declarations
   logic [1:0]  enable_reg;
   logic [2:0]  modeField_reg;
   logic [1:0]  pending_reg;
   logic [1:0]  ready_reg;
   logic [1:0]  err_reg;
   logic        cal_reg;
   logic        noRef_reg;
   logic        modeWrite;
   logic        statWrite;
   logic        launchNow;
   logic        allDone;
   logic [1:0]  wrEnable;
   logic [1:0]  wrReadyBits;
   logic [2:0]  wrMode;
   logic [1:0]  powerOn;
   logic [1:0]  filterRst;
   logic [1:0]  modClkEn;
   logic [1:0]  resultLoad;
   logic [1:0]  coefLoad;
   logic [1:0]  readySet;
   logic [1:0]  errSet;
   logic [1:0]  calSet;
   logic [1:0]  cycleEnd;
   logic [1:0]  calInhibit;
   logic [1:0]  forceOnes;
   logic        anyActive;
   logic [7:0]  statusByte;

   // ==================================================================
   // Bus decode
   assign modeWrite   = sfrWrEn && (sfrAddr == `DASMC_MODE_ADDR);
   assign statWrite   = sfrWrEn && (sfrAddr == `DASMC_STAT_ADDR);
   assign wrEnable    = {sfrWrData[`DASMC_MODE_PEN_BIT], sfrWrData[`DASMC_MODE_AEN_BIT]};
   assign wrMode      = sfrWrData[`DASMC_MODE_FLD_HI:`DASMC_MODE_FLD_LO];
   assign wrReadyBits = {sfrWrData[`DASMC_STAT_ARDY_BIT], sfrWrData[`DASMC_STAT_PRDY_BIT]};
   assign launchNow   = modeWrite && launches(wrMode);
   assign allDone     = (pending_reg != 2'h0) && ((pending_reg & ~cycleEnd) == 2'h0);
   assign calInhibit  = {auxTempSelected, 1'b0};                          // R21
   assign anyActive   = (enable_reg != 2'h0) && (modeField_reg != `DASMC_MD_PDOWN);
   assign forceOnes   = extRefSel & {2{noRef_reg}};                       // R7

   // ==================================================================
   // Mode register; index 0 primary, 1 auxiliary
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_reg    <= 2'h0;
         modeField_reg <= `DASMC_MD_PDOWN;                                // R14
      end else if (modeWrite) begin
         enable_reg    <= {wrEnable[0], wrEnable[1]};                     // R12 R13
         modeField_reg <= wrMode;
      end else if (allDone) begin
         modeField_reg <= `DASMC_MD_PDOWN;                                // R17 R20
      end
   end

   // ==================================================================
   // Outstanding one-shot cycles
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_reg <= 2'h0;
      end else if (modeWrite) begin
         pending_reg <= isOneShot(wrMode) ? {wrEnable[0], wrEnable[1]} : 2'h0;
      end else begin
         pending_reg <= pending_reg & ~cycleEnd;
      end
   end

   // ==================================================================
   // Per-converter sequencers and flags
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_conv
         dasmc_conv_seq u_seq (
            .ref_clk    (ref_clk),
            .rst_n      (rst_n),
            .convEnable (enable_reg[gi]),
            .modeField  (modeField_reg),
            .modeWrite  (modeWrite),
            .convDone   (convDone[gi]),
            .clampIn    (clampIn[gi]),
            .calFaultIn (calFaultIn[gi]),
            .calInhibit (calInhibit[gi]),
            .readyHeld  (ready_reg[gi]),
            .powerOn    (powerOn[gi]),
            .filterRst  (filterRst[gi]),
            .modClkEn   (modClkEn[gi]),
            .resultLoad (resultLoad[gi]),
            .coefLoad   (coefLoad[gi]),
            .readySet   (readySet[gi]),
            .errSet     (errSet[gi]),
            .calSet     (calSet[gi]),
            .cycleEnd   (cycleEnd[gi])
         );

         // Ready flag: hardware set wins over any clear
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               ready_reg[gi] <= 1'b0;
            end else if (readySet[gi]) begin
               ready_reg[gi] <= 1'b1;                                     // R1 R4
            end else if (launchNow && (wrMode[2] || wrEnable[1 - gi])) begin
               ready_reg[gi] <= 1'b0;                                     // R2 R20
            end else if (statWrite && !wrReadyBits[gi]) begin
               ready_reg[gi] <= 1'b0;                                     // R2
            end
         end

         // Error flag
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               err_reg[gi] <= 1'b0;
            end else if (errSet[gi]) begin
               err_reg[gi] <= 1'b1;                                       // R8 R9 R11
            end else if (launchNow) begin
               err_reg[gi] <= 1'b0;                                       // R10 R11
            end
         end
      end
   endgenerate

   // ==================================================================
   // Calibration and reference flags
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_reg <= 1'b0;
      end else if (calSet != 2'h0) begin
         cal_reg <= 1'b1;                                                 // R5
      end else if (launchNow) begin
         cal_reg <= 1'b0;                                                 // R5
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         noRef_reg <= 1'b0;
      end else begin
         noRef_reg <= refMissingIn && anyActive;                          // R6
      end
   end

   // ==================================================================
   // Results and coefficient strobes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         primaryResult <= 24'h000000;
      end else if (resultLoad[0]) begin
         primaryResult <= forceOnes[0] ? 24'hffffff : primaryRaw;         // R7 R17 R18
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         auxiliaryResult <= 16'h0000;
      end else if (resultLoad[1]) begin
         auxiliaryResult <= forceOnes[1] ? 16'hffff : auxiliaryRaw;       // R7 R17 R18
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         resultStrobe <= 2'h0;
         coefStrobe   <= 2'h0;
      end else begin
         resultStrobe <= resultLoad;
         coefStrobe   <= coefLoad;                                        // R9 R20 R21
      end
   end

   // ==================================================================
   // Converter control outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         convPowerOn   <= 2'h0;
         convFilterRst <= 2'h3;
         convModClkEn  <= 2'h0;
         opModeOut     <= `DASMC_MD_PDOWN;
      end else begin
         convPowerOn   <= powerOn;
         convFilterRst <= filterRst;
         convModClkEn  <= modClkEn;
         opModeOut     <= modeField_reg;
      end
   end

   // ==================================================================
   // Read data
   always_comb begin
      statusByte = `DASMC_STAT_RESET;
      statusByte[`DASMC_STAT_PRDY_BIT] = ready_reg[0];
      statusByte[`DASMC_STAT_ARDY_BIT] = ready_reg[1];
      statusByte[`DASMC_STAT_CAL_BIT]  = cal_reg;
      statusByte[`DASMC_STAT_NREF_BIT] = noRef_reg;
      statusByte[`DASMC_STAT_PERR_BIT] = err_reg[0];
      statusByte[`DASMC_STAT_AERR_BIT] = err_reg[1];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sfrRdData <= 8'h00;
      end else if (sfrRdEn) begin
         case (sfrAddr)
            `DASMC_MODE_ADDR: begin
               sfrRdData <= {2'h0, enable_reg[0], enable_reg[1], 1'b0, modeField_reg};
            end
            `DASMC_STAT_ADDR: begin
               sfrRdData <= statusByte;
            end
            default: begin
               sfrRdData <= 8'h00;
            end
         endcase
      end
   end

endmodule : dasmc_top
`default_nettype wire

/* File: dasmc_top_assertions.sv */
/*
 Concurrent checks on the ports of the converter mode and status block.
 Assumes binding to dasmc_top, one ref_clk domain and reset rst_n.
*/
`timescale 1ns/1ps
`default_nettype none

module dasmc_top_assertions (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // Register bus
   input wire logic [7:0]  sfrAddr,
   input wire logic        sfrWrEn,
   input wire logic        sfrRdEn,
   input wire logic [7:0]  sfrWrData,
   input wire logic [7:0]  sfrRdData,
   // Converter side
   input wire logic [1:0]  convDone,
   input wire logic [1:0]  extRefSel,
   input wire logic        refMissingIn,
   input wire logic        auxTempSelected,
   input wire logic [1:0]  convPowerOn,
   input wire logic [1:0]  convFilterRst,
   input wire logic [1:0]  convModClkEn,
   input wire logic [2:0]  opModeOut,
   input wire logic [23:0] primaryResult,
   input wire logic [1:0]  resultStrobe,
   input wire logic [1:0]  coefStrobe
);
   // ========
   // Clocking and sequences
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_mode_write;
      sfrWrEn && sfrAddr == 8'hd1;
   endsequence
   sequence s_mode_read;
      sfrRdEn && sfrAddr == 8'hd1;
   endsequence
   sequence s_cal_done;
      $past(convDone[0]) && $past(opModeOut[2]);
   endsequence

   // ========
   // Checks
   a_wr_mode_load: assert property (s_mode_write |-> ##2
      {5'h00, opModeOut} == ($past(sfrWrData, 2) & 8'h07)) else $error("mode field not loaded");
   a_rd_mode_field: assert property (s_mode_read |=>
      (sfrRdData & 8'hcf) == {5'h00, $past(opModeOut)}) else $error("mode read wrong");
   a_strobe_cause: assert property (resultStrobe[0] |-> $past(convDone[0]))
      else $error("primary strobe without done");
   a_aux_strobe_cause: assert property (resultStrobe[1] |-> $past(convDone[1]))
      else $error("auxiliary strobe without done");
   a_result_stable: assert property (!$past(convDone[0]) |-> $stable(primaryResult))
      else $error("primary result changed without done");
   a_coef_in_cal: assert property (coefStrobe[0] |-> s_cal_done)
      else $error("coefficient strobe outside calibration");
   a_aux_coef_temp: assert property (coefStrobe[1] |-> !$past(auxTempSelected))
      else $error("auxiliary coefficients written on temperature input");
   a_pdown_power: assert property ((opModeOut == 3'h0) [*2] |-> convPowerOn == 2'h0)
      else $error("converter powered in power-down");
   a_idle_held: assert property ((convPowerOn[0] && opModeOut == 3'h1) [*3] |->
      convFilterRst[0] && convModClkEn[0]) else $error("idle converter not held");
   a_ref_forced: assert property (convDone[0] && extRefSel[0] && refMissingIn &&
      $past(refMissingIn) |=> primaryResult == 24'hffffff || $stable(primaryResult))
      else $error("result not forced to all ones");
endmodule : dasmc_top_assertions

bind dasmc_top dasmc_top_assertions u_chk (.*);

`default_nettype wire

/* File: dasmc_filter_model.sv */
/*
 Filter model: pulses done after a set number of running cycles.
 Assumes power and filter reset controls from dasmc_top.
*/
`timescale 1ns/1ps
`default_nettype none

module dasmc_filter_model (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Converter control
   input  wire logic [1:0] powerOn,
   input  wire logic [1:0] filterRst,
   input  wire logic [7:0] latency,
   // Completion
   output logic      [1:0] convDone
);
   for (genvar i = 0; i < 2; i++) begin : g_conv
      logic [7:0] cntReg;
      logic       doneReg;
      assign convDone[i] = doneReg;
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n || !powerOn[i] || filterRst[i]) begin
            cntReg  <= 8'h00;
            doneReg <= 1'h0;
         end else begin
            cntReg  <= (cntReg == latency - 8'h01) ? 8'h00 : cntReg + 8'h01;
            doneReg <= (cntReg == latency - 8'h01);
         end
      end
   end
endmodule : dasmc_filter_model

`default_nettype wire

/* File: dasmc_tb_top.sv */
/*
 Self-checking bench for the converter mode and status block.
 Assumes dasmc_top, dasmc_filter_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))

module dasmc_tb_top;
   typedef struct packed {
      logic [7:0] wa;
      logic [7:0] wd;
      logic [7:0] ra;
      logic [7:0] ex;
   } dasmc_row_t;
   localparam dasmc_row_t ROWS [6] = '{'{8'hd1, 8'hcb, 8'hd1, 8'h03},
      '{8'hd1, 8'h09, 8'hd1, 8'h01}, '{8'hd1, 8'h00, 8'hd1, 8'h00},
      '{8'hd8, 8'hff, 8'hd8, 8'h00}, '{8'h55, 8'hff, 8'h55, 8'h00},
      '{8'hd1, 8'h30, 8'hd1, 8'h30}};
   // ========
   // Signals
   logic        ref_clk = 1'h0;
   logic        rst_n = 1'h0;
   logic        sfrWrEn = 1'h0;
   logic        sfrRdEn = 1'h0;
   logic        refMissingIn = 1'h0;
   logic        auxTempSelected = 1'h0;
   logic [7:0]  sfrAddr = 8'h00;
   logic [7:0]  sfrWrData = 8'h00;
   logic [7:0]  lat = 8'h04;
   logic [7:0]  sfrRdData, v;
   logic [1:0]  clampIn = 2'h0, calFaultIn = 2'h0, extRefSel = 2'h0;
   logic [1:0]  convDone, convPowerOn, convFilterRst, convModClkEn, resultStrobe, coefStrobe;
   logic [2:0]  opModeOut;
   logic [23:0] primaryRaw = 24'h000000, primaryResult;
   logic [15:0] auxiliaryRaw = 16'h0000, auxiliaryResult;
   int          nFail = 0, checksDone = 0, cyc = 0, c0, c1, n;
   int          nRs [2] = '{0, 0};
   int          nCs [2] = '{0, 0};

   dasmc_top u_dut (.*);
   dasmc_filter_model u_flt (.ref_clk(ref_clk), .rst_n(rst_n), .powerOn(convPowerOn),
      .filterRst(convFilterRst), .latency(lat), .convDone(convDone));

   // ========
   // Clock, strobe counters and timeout
   initial forever #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      for (int i = 0; i < 2; i++) begin
         nRs[i] += int'(resultStrobe[i] === 1'h1);
         nCs[i] += int'(coefStrobe[i] === 1'h1);
      end
      if (cyc == 20000) begin
         nFail++;
         conclude();
      end
   end

   // ========
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      if (nFail == 0 && checksDone > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfrAddr   <= a;
      sfrWrData <= d;
      sfrWrEn   <= 1'h1;
      @(posedge ref_clk);
      sfrWrEn   <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      sfrAddr <= a;
      sfrRdEn <= 1'h1;
      @(posedge ref_clk);
      sfrRdEn <= 1'h0;
      #1 d = sfrRdData;
   endtask : rd
   task automatic wt(input int kind, input int idx);
      for (int k = 0; k < 300; k++) begin
         @(posedge ref_clk);
         #1;
         if (kind == 0 ? resultStrobe[idx] === 1'h1 : opModeOut === 3'h0) break;
      end
   endtask : wt

   // ========
   // Sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'h1;
      foreach (ROWS[i]) begin
         wr(ROWS[i].wa, ROWS[i].wd);
         rd(ROWS[i].ra, v);
         `CHK(v, ROWS[i].ex);
      end
      // Single primary conversion with clamp
      clampIn    <= 2'h1;
      primaryRaw <= 24'h123456;
      n = nRs[0];
      wr(8'hd1, 8'h22);
      wt(0, 0);
      `CHK(primaryResult, 24'h123456);
      repeat (8) @(posedge ref_clk);
      `CHK(nRs[0] - n, 1);
      rd(8'hd1, v);
      `CHK(v, 8'h20);
      rd(8'hd8, v);
      `CHK(v, 8'h88);
      // Continuous, results blocked while ready
      clampIn    <= 2'h0;
      primaryRaw <= 24'h00abcd;
      lat        <= 8'h03;
      n = nRs[0];
      wr(8'hd1, 8'h23);
      wt(0, 0);
      primaryRaw <= 24'h00beef;
      repeat (30) @(posedge ref_clk);
      `CHK(nRs[0] - n, 1);
      `CHK(primaryResult, 24'h00abcd);
      rd(8'hd8, v);
      `CHK(v, 8'h80);
      wr(8'hd8, 8'h7f);
      wt(0, 0);
      `CHK(primaryResult, 24'h00beef);
      rd(8'hd1, v);
      `CHK(v, 8'h23);
      // Same-value rewrites keep restarting
      lat <= 8'h06;
      for (int i = 0; i < 12; i++) begin
         if (i == 2) n = nRs[0];
         wr(8'hd1, 8'h23);
      end
      `CHK(nRs[0] - n, 0);
      // Idle, then power-down
      wr(8'hd1, 8'h21);
      repeat (4) @(posedge ref_clk);
      #1 `CHK(convFilterRst[0] & convModClkEn[0], 1'h1);
      wr(8'hd1, 8'h00);
      repeat (3) @(posedge ref_clk);
      #1 `CHK(convPowerOn, 2'h0);
      // All calibration codes, fault on odd codes
      lat <= 8'h08;
      for (int m = 4; m < 8; m++) begin
         calFaultIn <= 2'(m % 2);
         c0 = nCs[0];
         wr(8'hd1, 8'h20 | 8'(m));
         rd(8'hd8, v);
         `CHK(v[7], 1'h0);
         wt(1, 0);
         repeat (3) @(posedge ref_clk);
         `CHK(nCs[0] - c0, 1 - m % 2);
         rd(8'hd8, v);
         `CHK(v, 8'ha0 | 8'(m % 2 * 8));
      end
      // Both calibrate, auxiliary on temperature input
      auxTempSelected <= 1'h1;
      calFaultIn      <= 2'h0;
      c0 = nCs[0];
      c1 = nCs[1];
      wr(8'hd1, 8'h34);
      wt(1, 0);
      repeat (3) @(posedge ref_clk);
      `CHK(nCs[1] - c1, 0);
      `CHK(nCs[0] - c0, 1);
      rd(8'hd8, v);
      `CHK(v, 8'he4);
      // Missing external reference
      auxTempSelected <= 1'h0;
      refMissingIn    <= 1'h1;
      extRefSel       <= 2'h1;
      lat             <= 8'h0c;
      rd(8'hd8, v);
      `CHK(v[4], 1'h0);
      wr(8'hd1, 8'h22);
      repeat (3) @(posedge ref_clk);
      rd(8'hd8, v);
      `CHK(v[4], 1'h1);
      wt(0, 0);
      `CHK(primaryResult, 24'hffffff);
      refMissingIn <= 1'h0;
      // Auxiliary single, primary stays down
      auxiliaryRaw <= 16'h5a5a;
      wr(8'hd1, 8'h12);
      repeat (3) @(posedge ref_clk);
      #1 `CHK(convPowerOn, 2'h2);
      wt(0, 1);
      `CHK(auxiliaryResult, 16'h5a5a);
      rd(8'hd8, v);
      `CHK(v & 8'h44, 8'h40);
      // Reset in mid-run
      wr(8'hd1, 8'h23);
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'h0;
      @(posedge ref_clk);
      #1 `CHK({convPowerOn, convFilterRst, opModeOut}, 7'h18);
      @(posedge ref_clk);
      rst_n <= 1'h1;
      rd(8'hd1, v);
      `CHK(v, 8'h00);
      rd(8'hd8, v);
      `CHK(v, 8'h00);
      conclude();
   end
endmodule : dasmc_tb_top

`default_nettype wire
